// [rtl/pmcd_top.sv]
// Power mode control and peripheral clock divider top
// What this block does
// RQ1: Idle halts core until reset or interrupt
// RQ2: Idle keeps peripheral clocks; interrupts wake core
// RQ3: Idle gates core, memory and bus clocks
// RQ4: Power-down stops oscillator and all clocks except the RTC clock when the external RTC bit is set
// RQ5: Power-down holds state and static pins
// RQ6: Power-down ends on reset or clockless interrupt
// RQ7: External RTC clock keeps RTC in power-down
// RQ8: Each peripheral switchable off by software
// RQ9: Divider gives full, half, quarter rate
// RQ10: Divider resets to quarter rate
// RQ11: Divider setting written over register bus
// RQ12: PLL kept running through idle
// RQ13: Mode request bit cleared on wake
// RQ14: Ratio change without short clock phases
`timescale 1ns/1ps
module pmcd_top
  import pmcd_pkg::*;
#(
  parameter int NP = NUM_PERIPH
)
(
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [DATA_W-1:0]   reg_rdata,
  input  wire logic                irq_any,
  input  wire logic                irq_clockless,
  input  wire logic                pll_running,
  output logic                     core_clock_en,
  output logic                     core_halt,
  output logic                     mem_bus_clock_en,
  output logic                     pclk_en,
  output logic      [NP-1:0]       periph_clock_en,
  output logic                     osc_enable,
  output logic                     pll_keep,
  output logic                     rtc_clock_en,
  output logic                     pin_hold
);
  import pmcd_pkg::*;

  pmcd_state_t      state_reg;
  pmcd_state_t      state_next;
  logic [2:0]       mode_reg;
  logic [NP-1:0]    periph_reg;
  logic [1:0]       div_reg;
  logic             pll_was_reg;
  logic             wake;
  logic             div_tick;
  pmcd_div_if       dvif ();

  // RQ1: wake conditions per mode
  always_comb
  begin
    unique case (state_reg)
      PMCD_IDLE:  wake = irq_any;
      // RQ6: clockless interrupt only
      PMCD_PDOWN: wake = irq_clockless;
      default:    wake = 1'b0;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      PMCD_RUN:
      begin
        if (mode_reg[MODE_PDOWN_BIT])
          state_next = PMCD_PDOWN;
        else if (mode_reg[MODE_IDLE_BIT])
          state_next = PMCD_IDLE;
      end
      PMCD_IDLE:
      begin
        if (wake)
          state_next = PMCD_RUN;
      end
      PMCD_PDOWN:
      begin
        if (wake)
          state_next = PMCD_RUN;
      end
      default: state_next = PMCD_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= PMCD_RUN;
    else
      state_reg <= state_next;
  end

  // RQ13: request bits set by write, cleared on wake
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      mode_reg <= MODE_RESET;
    else if (state_reg != PMCD_RUN && wake)
      mode_reg <= {mode_reg[MODE_RTCX_BIT], 2'b00};
    else if (reg_wr && reg_addr == OFS_MODE && state_reg == PMCD_RUN)
      mode_reg <= reg_wdata[2:0];
  end

  // RQ8: peripheral power switches
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      periph_reg <= NP'(PERIPH_RESET);
    else if (reg_wr && reg_addr == OFS_PERIPH)
      periph_reg <= reg_wdata[NP-1:0];
  end

  // RQ11: divider set via bus
  // RQ10: quarter rate at reset
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      div_reg <= DIV_RESET;
    else if (reg_wr && reg_addr == OFS_DIV && reg_wdata[1:0] != 2'h3)
      div_reg <= reg_wdata[1:0];
  end

  // RQ12: remember PLL state before idle
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      pll_was_reg <= 1'b0;
    else if (state_reg == PMCD_RUN)
      pll_was_reg <= pll_running;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_MODE:   reg_rdata <= DATA_W'(mode_reg);
        OFS_PERIPH: reg_rdata <= DATA_W'(periph_reg);
        OFS_DIV:    reg_rdata <= DATA_W'(div_reg);
        OFS_STATUS: reg_rdata <= DATA_W'({pll_was_reg, state_reg});
        default:    reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end

  // RQ9: divider instance
  assign dvif.ratio = div_reg;
  // RQ4: no peripheral clock in power-down
  assign dvif.run   = (state_next != PMCD_PDOWN);
  assign div_tick   = dvif.tick;
  assign pclk_en    = div_tick;

  pmcd_divider u_div (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .dv      (dvif),
    .pclk_en ()
  );

  // RQ3: core, memory and bus gated in low power
  assign core_clock_en    = (state_reg == PMCD_RUN);
  assign core_halt        = (state_reg != PMCD_RUN);
  assign mem_bus_clock_en = (state_reg == PMCD_RUN);
  // RQ2: peripherals clocked unless powered down
  assign periph_clock_en  = (state_reg == PMCD_PDOWN) ? '0 : periph_reg;
  // RQ4: oscillator off in power-down
  assign osc_enable       = (state_reg != PMCD_PDOWN);
  // RQ12: PLL kept in idle
  assign pll_keep         = (state_reg == PMCD_RUN) ? pll_running :
                            (state_reg == PMCD_IDLE) ? pll_was_reg : 1'b0;
  // RQ7: RTC on external clock survives power-down
  assign rtc_clock_en     = (state_reg != PMCD_PDOWN) ||
                            mode_reg[MODE_RTCX_BIT];
  // RQ5: pins and state frozen
  assign pin_hold         = (state_reg == PMCD_PDOWN);
endmodule

// [rtl/pmcd_pkg.sv]
// Package of constants for the power mode and peripheral clock divider
package pmcd_pkg;
  localparam int          ADDR_W         = 4;
  localparam int          DATA_W         = 32;
  localparam int          NUM_PERIPH     = 8;
  localparam logic [3:0]  OFS_MODE       = 4'h0;
  localparam logic [3:0]  OFS_PERIPH     = 4'h4;
  localparam logic [3:0]  OFS_DIV        = 4'h8;
  localparam logic [3:0]  OFS_STATUS     = 4'hc;
  localparam int          MODE_IDLE_BIT  = 0;
  localparam int          MODE_PDOWN_BIT = 1;
  localparam int          MODE_RTCX_BIT  = 2;
  localparam logic [1:0]  DIV_QUARTER    = 2'h0;
  localparam logic [1:0]  DIV_FULL       = 2'h1;
  localparam logic [1:0]  DIV_HALF       = 2'h2;
  localparam logic [1:0]  DIV_RESET      = 2'h0;
  localparam logic [7:0]  PERIPH_RESET   = 8'hff;
  localparam logic [2:0]  MODE_RESET     = 3'h0;
  typedef enum logic [1:0] {PMCD_RUN, PMCD_IDLE, PMCD_PDOWN} pmcd_state_t;
endpackage

// [rtl/pmcd_div_if.sv]
// Interface between control logic and clock divider
`timescale 1ns/1ps
interface pmcd_div_if;
  logic [1:0] ratio;
  logic       run;
  logic       tick;
  modport ctrl (output ratio, output run, input tick);
  modport div  (input ratio, input run, output tick);
endinterface

// [rtl/pmcd_divider.sv]
// Glitch-free peripheral clock enable divider
`timescale 1ns/1ps
module pmcd_divider
  import pmcd_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  pmcd_div_if.div   dv,
  output logic      pclk_en
);
  logic [1:0] cnt_reg;
  logic [1:0] ratio_reg;
  logic [1:0] last;
  always_comb
  begin
    unique case (ratio_reg)
      DIV_FULL: last = 2'h0;
      DIV_HALF: last = 2'h1;
      default:  last = 2'h3;
    endcase
  end
  // RQ14: ratio only at period end
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg   <= 2'h0;
      ratio_reg <= DIV_RESET;
    end
    else if (dv.run)
    begin
      if (cnt_reg >= last)
      begin
        cnt_reg   <= 2'h0;
        ratio_reg <= dv.ratio;
      end
      else
        cnt_reg <= cnt_reg + 2'h1;
    end
  end
  // RQ9: one tick per period
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      pclk_en <= 1'b0;
    else
      pclk_en <= dv.run && (cnt_reg >= last);
  end
  assign dv.tick = pclk_en;
endmodule

// [verification/pmcd_top_properties.sv]
// Checker for the power mode and divider top
`timescale 1ns/1ps
module pmcd_props
  import pmcd_pkg::*;
#(
  parameter int NP = 8
)
(
  input wire logic                           ref_clk,
  input wire logic                           arst_n,
  input wire logic [pmcd_pkg::ADDR_W-1:0]    reg_addr,
  input wire logic [pmcd_pkg::DATA_W-1:0]    reg_wdata,
  input wire logic                           reg_wr,
  input wire logic                           reg_rd,
  input wire logic [pmcd_pkg::DATA_W-1:0]    reg_rdata,
  input wire logic                           irq_any,
  input wire logic                           irq_clockless,
  input wire logic                           pll_running,
  input wire logic                           core_clock_en,
  input wire logic                           core_halt,
  input wire logic                           mem_bus_clock_en,
  input wire logic                           pclk_en,
  input wire logic [NP-1:0]                  periph_clock_en,
  input wire logic                           osc_enable,
  input wire logic                           pll_keep,
  input wire logic                           rtc_clock_en,
  input wire logic                           pin_hold
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_HALT_GATE: assert property (
    core_halt |-> !core_clock_en && !mem_bus_clock_en)
    else $error("core clocks run while halted");
  AST_IDLE_WAKE: assert property (
    core_halt && osc_enable && irq_any |=> !core_halt)
    else $error("interrupt did not end idle");
  AST_IDLE_HOLD: assert property (
    core_halt && osc_enable && !irq_any && !irq_clockless |=> core_halt)
    else $error("idle left without cause");
  AST_PD_STOP: assert property (
    !osc_enable |-> pin_hold && !pll_keep && !pclk_en &&
                    periph_clock_en == '0)
    else $error("clocks alive in power-down");
  AST_PD_WAKE: assert property (
    !osc_enable && irq_clockless |=> osc_enable)
    else $error("power-down not ended");
  AST_PD_STAY: assert property (
    !osc_enable && !irq_clockless |=> !osc_enable)
    else $error("power-down left without cause");
  AST_RTC_RUN: assert property (
    osc_enable |-> rtc_clock_en)
    else $error("rtc stopped outside power-down");
  AST_PLL_RUN: assert property (
    core_clock_en |-> pll_keep == pll_running)
    else $error("pll hold wrong in run");
  AST_PERIPH_WR: assert property (
    reg_wr && reg_addr == OFS_PERIPH |=>
      !osc_enable || periph_clock_en == $past(reg_wdata[NP-1:0]))
    else $error("peripheral enables not written");
  AST_RD_ZERO: assert property (
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside read slot");
  AST_PCLK_MAX: assert property (
    pclk_en && osc_enable |-> ##[1:4] (pclk_en || !osc_enable))
    else $error("peripheral clock too slow");
  AST_PCLK_GAP: assert property (
    pclk_en ##1 (!pclk_en && osc_enable) [*2] |=> !pclk_en)
    else $error("short peripheral clock period");
  cover property (core_halt && osc_enable ##1 !core_halt);
  cover property (!osc_enable ##1 osc_enable);
  cover property (pclk_en ##1 pclk_en);
endmodule
bind pmcd_top pmcd_props #(.NP(NP)) pmcd_props_i (.*);

// [verification/pmcd_core_model.sv]
// Interrupt source model on the core side
`timescale 1ns/1ps
module pmcd_core_model
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       go,
  input  wire logic       pd,
  input  wire logic [3:0] dly,
  output logic            irq_any,
  output logic            irq_clockless
);
  logic [3:0] cnt_reg;
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      cnt_reg <= 4'h0;
    else if (go)
      cnt_reg <= dly;
    else if (cnt_reg != 4'h0)
      cnt_reg <= cnt_reg - 4'h1;
  assign irq_any       = cnt_reg == 4'h1 && !pd;
  assign irq_clockless = cnt_reg == 4'h1 && pd;
endmodule

// [verification/pmcd_top_tb.sv]
// Testbench for the power mode and divider top
`timescale 1ns/1ps
module pmcd_top_tb;
  import pmcd_pkg::*;
  logic ref_clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic pll_running = 1'h0, go = 1'h0, pd = 1'h0;
  logic [3:0] dly = 4'h1, reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic irq_any, irq_clockless, core_clock_en, core_halt, mem_bus_clock_en;
  logic pclk_en, osc_enable, pll_keep, rtc_clock_en, pin_hold;
  logic [7:0] periph_clock_en, pv;
  logic [1:0] r;
  int num_errors = 0, check_count = 0, n;
  pmcd_top #(.NP(8)) pmcd_top_i (.*);
  pmcd_core_model pmcd_core_model_i (.*);
  initial forever #50 ref_clk = ~ref_clk;
  function automatic int rate(logic [1:0] d);
    return d == DIV_FULL ? 16 : d == DIV_HALF ? 8 : 4;
  endfunction
  task automatic chk(string nm, logic [31:0] got, logic [31:0] e);
    check_count++;
    if (got !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e, string nm);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 chk(nm, reg_rdata, e);
  endtask
  task automatic pc(int e);
    n = 0;
    repeat (16) @(posedge ref_clk) #1 n += int'(pclk_en);
    chk("pclk", n, e);
  endtask
  task automatic fire(logic p);
    @(posedge ref_clk);
    pd <= p;
    dly <= 4'($urandom_range(8, 1));
    go <= 1'h1;
    @(posedge ref_clk);
    go <= 1'h0;
    repeat (12) @(posedge ref_clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(32'h3260));
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'h1;
    rd(OFS_MODE, 32'h0, "mode");
    rd(OFS_PERIPH, 32'hff, "periph");
    rd(OFS_DIV, 32'h0, "div");
    rd(4'h2, 32'h0, "unmapped");
    pc(4);
    for (int i = 1; i < 5; i++)
    begin
      wr(OFS_DIV, i % 4);
      if (i != 3)
        r = 2'(i);
      repeat (8) @(posedge ref_clk);
      pc(rate(r));
    end
    pv = 8'($urandom);
    wr(OFS_PERIPH, {24'h0, pv});
    rd(OFS_PERIPH, {24'h0, pv}, "periph rb");
    chk("pce", periph_clock_en, pv);
    pll_running <= 1'h1;
    wr(OFS_MODE, 32'h1);
    @(posedge ref_clk);
    pll_running <= 1'h0;
    repeat (2) @(posedge ref_clk);
    #1 chk("idle", {core_halt, core_clock_en, mem_bus_clock_en,
                    osc_enable, pll_keep}, 5'h13);
    rd(OFS_STATUS, 32'h5, "status");
    pc(4);
    fire(1'h0);
    chk("wake", core_halt, 1'h0);
    rd(OFS_MODE, 32'h0, "mode clr");
    for (int j = 0; j < 2; j++)
    begin
      wr(OFS_MODE, j ? 32'h6 : 32'h2);
      repeat (3) @(posedge ref_clk);
      fire(1'h0);
      chk("pd", {osc_enable, pin_hold, rtc_clock_en}, {2'h1, j[0]});
      chk("pd pce", periph_clock_en, 8'h0);
      fire(1'h1);
      chk("pd wake", {osc_enable, core_halt}, 2'h2);
      chk("pce back", periph_clock_en, pv);
      rd(OFS_MODE, {29'h0, j[0], 2'h0}, "pd clr");
    end
    wrap_up();
  end
endmodule
